// [hw/sb_state_pkg.sv]
// constants, types and state encodings of the sideband package/channel state controller
`default_nettype none
package sb_state_pkg;

  localparam int CLK_PERIOD_NS = 5;
  localparam int T4_US = 2000;
  localparam int T4_CYC_DEF = (T4_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PKG_DLY_DEF = 64;
  localparam int CH_DLY_DEF = 128;
  localparam int CNT_W = 20;

  ////////////////////////////////////////////////////////////////////////////////
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_IRQ_STAT = 5'h08;
  localparam logic [4:0] REG_IRQ_MASK = 5'h0C;

  localparam int CTRL_FORCE_INIT = 0;
  localparam int CTRL_ARB_SUP = 1;
  localparam logic CTRL_ARB_SUP_RST = 1'b1;

  localparam int ST_PWR = 0;
  localparam int ST_PKG_READY = 1;
  localparam int ST_SELECTED = 2;
  localparam int ST_ARB_EN = 3;
  localparam int ST_TOKEN = 4;
  localparam int ST_DRV_EN = 5;
  localparam int ST_INIT_LSB = 8;
  localparam int ST_ENA_LSB = 16;

  localparam int IRQ_W = 4;
  localparam int IRQ_INIT_ENTERED = 0;
  localparam int IRQ_SEL_CHANGED = 1;
  localparam int IRQ_INIT_FAIL = 2;
  localparam int IRQ_POWER_DOWN = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

  ////////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] OP_CLEAR_INIT = 8'h20;
  localparam logic [7:0] OP_SELECT = 8'h21;
  localparam logic [7:0] OP_DESELECT = 8'h22;
  localparam logic [7:0] OP_CH_ENABLE = 8'h23;
  localparam logic [7:0] OP_CH_DISABLE = 8'h24;
  localparam logic [7:0] OP_CH_RESET = 8'h25;
  localparam logic [4:0] PKG_CHAN = 5'h1F;

  typedef struct packed {
    logic valid;
    logic [7:0] chid;
    logic [7:0] op;
    logic oem;
    logic arg;
  } cmd_t;

  typedef struct packed {
    logic valid;
    logic ok;
    logic fail_init;
  } rsp_t;

  typedef struct packed {
    logic clear_init;
    logic enable;
    logic disable_ch;
    logic reset_ch;
  } ch_cmd_t;

  typedef enum logic [2:0] {CH_OFF, CH_NOT_READY, CH_INITIAL, CH_DISABLED, CH_ENABLED} ch_state_t;
  typedef enum logic [1:0] {PK_DOWN, PK_NOT_READY, PK_READY} pkg_state_t;

endpackage : sb_state_pkg
`default_nettype wire

// [hw/sb_chan_state.sv]
// one channel: power-up delay, initial state, enabled and disabled sub-states
`timescale 1ns/10ps
`default_nettype none
module sb_chan_state
  import sb_state_pkg::*;
#(
  parameter int DLY_CYC = CH_DLY_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic power_up,
  input wire logic force_init,
  input wire ch_cmd_t cmd,
  output ch_state_t state
);

  typedef struct packed {
    ch_state_t st;
    logic [CNT_W-1:0] cnt;
  } chan_t;

  localparam chan_t CHAN_RST = '{st: CH_OFF, cnt: '0};

  chan_t s_reg;
  chan_t s_next;

  always_comb begin
    s_next = s_reg;
    case (s_reg.st)
      CH_OFF: begin
        if (power_up) begin
          s_next.st = CH_NOT_READY;
          s_next.cnt = '0;
        end
      end
      CH_NOT_READY: begin
        s_next.cnt = s_reg.cnt + CNT_W'(1);
        if (s_reg.cnt >= CNT_W'(DLY_CYC - 1)) begin
          s_next.st = CH_INITIAL;
        end
      end
      CH_INITIAL: begin
        if (cmd.clear_init) begin
          s_next.st = CH_DISABLED;
        end
      end
      CH_DISABLED: begin
        if (cmd.reset_ch) begin
          s_next.st = CH_INITIAL;
        end else if (cmd.enable) begin
          s_next.st = CH_ENABLED;
        end
      end
      CH_ENABLED: begin
        if (cmd.reset_ch) begin
          s_next.st = CH_INITIAL;
        end else if (cmd.disable_ch) begin
          s_next.st = CH_DISABLED;
        end
      end
      default: s_next.st = CH_OFF;
    endcase
    // loss of settings drops straight into initial, never into enabled
    if (force_init && (s_reg.st == CH_DISABLED || s_reg.st == CH_ENABLED)) begin
      s_next.st = CH_INITIAL;
    end
    if (!power_up) begin
      s_next.st = CH_OFF;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= CHAN_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign state = s_reg.st;

  property p_init_hold;
    @(posedge clk) disable iff (!rst_n)
      (s_reg.st == CH_INITIAL && power_up && !cmd.clear_init) |=> (s_reg.st == CH_INITIAL);
  endproperty
  a_init_hold: assert property (p_init_hold) else $error("initial state left without clear");

  property p_init_exit;
    @(posedge clk) disable iff (!rst_n)
      (s_reg.st == CH_INITIAL) |=> (s_reg.st inside {CH_INITIAL, CH_DISABLED, CH_OFF});
  endproperty
  a_init_exit: assert property (p_init_exit) else $error("initial state left to enabled");

endmodule : sb_chan_state
`default_nettype wire

// [hw/sb_tx_gate.sv]
// transmit gate: driver enable and grants from selection, arbitration and channel enables
`timescale 1ns/10ps
`default_nettype none
module sb_tx_gate
  import sb_state_pkg::*;
#(
  parameter int N = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic powered,
  input wire logic selected,
  input wire logic arb_en,
  input wire logic token,
  input wire logic rsp_req,
  input wire logic [N-1:0] unreq_req,
  input wire logic [N-1:0] ch_enabled,
  output logic drv_en,
  output logic rsp_gnt,
  output logic [N-1:0] unreq_gnt
);

  typedef struct packed {
    logic drv;
    logic rsp;
    logic [N-1:0] unreq;
  } gate_t;

  gate_t g_reg;
  gate_t g_next;
  logic may_tx;
  logic [N-1:0] elig;

  always_comb begin
    g_next = '0;
    // losing the token mid-frame cuts the grant; the framer must abort cleanly
    may_tx = powered && selected && (!arb_en || token);
    elig = unreq_req & ch_enabled;
    g_next.rsp = may_tx && rsp_req;
    if (may_tx && !rsp_req) begin
      g_next.unreq = elig & (~elig + {{(N-1){1'b0}}, 1'b1});
    end
    g_next.drv = g_next.rsp || (|g_next.unreq);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      g_reg <= '0;
    end else begin
      g_reg <= g_next;
    end
  end

  assign drv_en = g_reg.drv;
  assign rsp_gnt = g_reg.rsp;
  assign unreq_gnt = g_reg.unreq;

  property p_drv_sel;
    @(posedge clk) disable iff (!rst_n)
      g_reg.drv |-> ($past(selected) && $past(powered));
  endproperty
  a_drv_sel: assert property (p_drv_sel) else $error("drivers on while not selected");

  property p_arb_token;
    @(posedge clk) disable iff (!rst_n)
      (g_reg.drv && $past(arb_en)) |-> $past(token);
  endproperty
  a_arb_token: assert property (p_arb_token) else $error("transmit without token");

  property p_no_arb;
    @(posedge clk) disable iff (!rst_n)
      (powered && selected && !arb_en && rsp_req) |=> (rsp_gnt && drv_en);
  endproperty
  a_no_arb: assert property (p_no_arb) else $error("selected package not granted");

  property p_unreq_ena;
    @(posedge clk) disable iff (!rst_n)
      (unreq_gnt != '0) |-> ((unreq_gnt & ~$past(ch_enabled)) == '0);
  endproperty
  a_unreq_ena: assert property (p_unreq_ena) else $error("disabled channel sent unrequested");

endmodule : sb_tx_gate
`default_nettype wire

// [hw/sb_pkg_ctrl.sv]
// package/channel operating-state controller with Avalon-MM registers and interrupt
`timescale 1ns/10ps
`default_nettype none
module sb_pkg_ctrl
  import sb_state_pkg::*;
#(
  parameter int NUM_CH = 2,
  parameter int T4_CYC = T4_CYC_DEF,
  parameter int PKG_DLY = PKG_DLY_DEF,
  parameter int CH_DLY = CH_DLY_DEF
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic IF_POWER,
  input wire logic ARB_TOKEN,
  input wire logic [2:0] PKG_ID_STRAP,
  input wire cmd_t CMD,
  output var rsp_t RSP,
  input wire logic TX_RSP_REQ,
  input wire logic [NUM_CH-1:0] TX_UNREQ_REQ,
  output logic TX_DRV_EN,
  output logic TX_RSP_GNT,
  output logic [NUM_CH-1:0] TX_UNREQ_GNT,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic IRQ
);

  typedef struct packed {
    logic pwr_s1;
    logic pwr_s2;
    logic tok_s1;
    logic tok_s2;
    logic [2:0] id_s1;
    logic [2:0] id_s2;
    logic [1:0] id_age;
    logic [2:0] pkg_id;
    pkg_state_t pst;
    logic [CNT_W-1:0] pcnt;
    logic selected;
    logic arb_en;
    logic arb_sup;
    logic force_init;
    logic [NUM_CH-1:0] init_prev;
    rsp_t rsp;
    logic waitreq;
    logic [31:0] rdata;
    logic [IRQ_W-1:0] clr_mask;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
  } top_t;

  localparam top_t TOP_RST = '{
    pst: PK_DOWN,
    arb_sup: CTRL_ARB_SUP_RST,
    waitreq: 1'b1,
    irq_mask: IRQ_MASK_RST,
    default: '0
  };

  top_t s_reg;
  top_t s_next;

  ch_state_t ch_st [NUM_CH];
  ch_cmd_t ch_cmd [NUM_CH];
  logic [NUM_CH-1:0] hit;
  logic [NUM_CH-1:0] ch_rdy;
  logic [NUM_CH-1:0] ch_init;
  logic [NUM_CH-1:0] ch_ena;
  logic pkg_cmd;
  logic pkg_sel_op;
  logic fail_init_now;
  logic gate_drv;
  logic gate_rsp;
  logic [NUM_CH-1:0] gate_unreq;

  ////////////////////////////////////////////////////////////////////////////////
  // package-level decode
  assign pkg_cmd = CMD.valid && (CMD.chid == {s_reg.pkg_id, PKG_CHAN});
  assign pkg_sel_op = (CMD.op == OP_SELECT) || (CMD.op == OP_DESELECT);
  // only non-vendor commands other than clear-initial are refused in initial state
  assign fail_init_now = |(hit & ch_init) && !CMD.oem && (CMD.op != OP_CLEAR_INIT);

  ////////////////////////////////////////////////////////////////////////////////
  // per-channel address match and state
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      assign hit[gi] = CMD.valid && (CMD.chid == {s_reg.pkg_id, 5'(gi)});
      assign ch_rdy[gi] = ch_st[gi] inside {CH_INITIAL, CH_DISABLED, CH_ENABLED};
      assign ch_init[gi] = (ch_st[gi] == CH_INITIAL);
      assign ch_ena[gi] = (ch_st[gi] == CH_ENABLED);
      // a refused command must not move the channel
      always_comb begin
        ch_cmd[gi].clear_init = hit[gi] && ch_rdy[gi] && (CMD.op == OP_CLEAR_INIT);
        ch_cmd[gi].enable = hit[gi] && ch_rdy[gi] && !fail_init_now && (CMD.op == OP_CH_ENABLE);
        ch_cmd[gi].disable_ch = hit[gi] && ch_rdy[gi] && !fail_init_now &&
                                (CMD.op == OP_CH_DISABLE);
        ch_cmd[gi].reset_ch = hit[gi] && ch_rdy[gi] && !fail_init_now && (CMD.op == OP_CH_RESET);
      end
      sb_chan_state #(
        .DLY_CYC(CH_DLY)
      ) u_chan (
        .clk(MCLK),
        .rst_n(RST_N),
        .power_up(s_reg.pwr_s2),
        .force_init(s_reg.force_init),
        .cmd(ch_cmd[gi]),
        .state(ch_st[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  sb_tx_gate #(
    .N(NUM_CH)
  ) u_gate (
    .clk(MCLK),
    .rst_n(RST_N),
    .powered(s_reg.pwr_s2),
    .selected(s_reg.selected),
    .arb_en(s_reg.arb_en),
    .token(s_reg.tok_s2),
    .rsp_req(TX_RSP_REQ),
    .unreq_req(TX_UNREQ_REQ),
    .ch_enabled(ch_ena),
    .drv_en(gate_drv),
    .rsp_gnt(gate_rsp),
    .unreq_gnt(gate_unreq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic ack;
    logic [31:0] rd;
    logic [IRQ_W-1:0] ev;
    ack = 1'b0;
    rd = '0;
    ev = '0;
    s_next = s_reg;

    // pin synchronisers and strap capture after reset release
    s_next.pwr_s1 = IF_POWER;
    s_next.pwr_s2 = s_reg.pwr_s1;
    s_next.tok_s1 = ARB_TOKEN;
    s_next.tok_s2 = s_reg.tok_s1;
    s_next.id_s1 = PKG_ID_STRAP;
    s_next.id_s2 = s_reg.id_s1;
    if (s_reg.id_age != 2'h3) begin
      s_next.id_age = s_reg.id_age + 2'h1;
      s_next.pkg_id = s_reg.id_s2;
    end

    // package readiness
    case (s_reg.pst)
      PK_DOWN: begin
        if (s_reg.pwr_s2) begin
          s_next.pst = PK_NOT_READY;
          s_next.pcnt = '0;
          s_next.arb_en = s_reg.arb_sup;
        end
      end
      PK_NOT_READY: begin
        s_next.pcnt = s_reg.pcnt + CNT_W'(1);
        if (s_reg.pcnt >= CNT_W'(PKG_DLY - 1)) begin
          s_next.pst = PK_READY;
        end
      end
      PK_READY: begin
      end
      default: s_next.pst = PK_DOWN;
    endcase

    // command answer, one cycle after the command
    s_next.rsp = '0;
    if (pkg_cmd && s_reg.pst == PK_READY) begin
      s_next.rsp.valid = 1'b1;
      s_next.rsp.ok = pkg_sel_op;
      if (CMD.op == OP_SELECT) begin
        s_next.selected = 1'b1;
        s_next.arb_en = s_reg.arb_sup && !CMD.arg;
      end else if (CMD.op == OP_DESELECT) begin
        s_next.selected = 1'b0;
      end
    end else if (|(hit & ch_rdy)) begin
      s_next.rsp.valid = 1'b1;
      s_next.rsp.ok = !fail_init_now;
      s_next.rsp.fail_init = fail_init_now;
    end
    if (!s_reg.pwr_s2) begin
      s_next.pst = PK_DOWN;
      s_next.selected = 1'b0;
      s_next.rsp = '0;
    end

    // events
    s_next.init_prev = ch_init;
    ev[IRQ_INIT_ENTERED] = |(ch_init & ~s_reg.init_prev);
    ev[IRQ_SEL_CHANGED] = (s_next.selected != s_reg.selected);
    ev[IRQ_INIT_FAIL] = s_next.rsp.fail_init;
    ev[IRQ_POWER_DOWN] = (s_reg.pst != PK_DOWN) && !s_reg.pwr_s2;

    // register read data
    case (AVS_ADDRESS)
      REG_CTRL: rd[CTRL_ARB_SUP] = s_reg.arb_sup;
      REG_STATUS: begin
        rd[ST_PWR] = s_reg.pwr_s2;
        rd[ST_PKG_READY] = (s_reg.pst == PK_READY);
        rd[ST_SELECTED] = s_reg.selected;
        rd[ST_ARB_EN] = s_reg.arb_en;
        rd[ST_TOKEN] = s_reg.tok_s2;
        rd[ST_DRV_EN] = gate_drv;
        rd[ST_INIT_LSB +: NUM_CH] = ch_init;
        rd[ST_ENA_LSB +: NUM_CH] = ch_ena;
      end
      // include this cycle's events so a bit set at capture is reported, not lost
      REG_IRQ_STAT: rd[IRQ_W-1:0] = s_reg.irq_stat | ev;
      REG_IRQ_MASK: rd[IRQ_W-1:0] = s_reg.irq_mask;
      default: rd = '0;
    endcase

    // one wait state per access
    s_next.force_init = 1'b0;
    if ((AVS_READ || AVS_WRITE) && s_reg.waitreq) begin
      s_next.waitreq = 1'b0;
      s_next.rdata = rd;
      s_next.clr_mask = (AVS_READ && AVS_ADDRESS == REG_IRQ_STAT) ? rd[IRQ_W-1:0] : '0;
    end else begin
      s_next.waitreq = 1'b1;
      ack = (AVS_READ || AVS_WRITE) && !s_reg.waitreq;
    end
    if (ack && AVS_WRITE && AVS_BYTEENABLE[0]) begin
      if (AVS_ADDRESS == REG_CTRL) begin
        s_next.force_init = AVS_WRITEDATA[CTRL_FORCE_INIT];
        s_next.arb_sup = AVS_WRITEDATA[CTRL_ARB_SUP];
      end else if (AVS_ADDRESS == REG_IRQ_MASK) begin
        s_next.irq_mask = AVS_WRITEDATA[IRQ_W-1:0];
      end
    end

    // read clears only the bits it reported; a new event wins
    if (ack && AVS_READ) begin
      s_next.irq_stat = (s_reg.irq_stat & ~s_reg.clr_mask) | ev;
    end else begin
      s_next.irq_stat = s_reg.irq_stat | ev;
    end
    s_next.irq = |(s_next.irq_stat & s_next.irq_mask);
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      s_reg <= TOP_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign RSP = s_reg.rsp;
  assign TX_DRV_EN = gate_drv;
  assign TX_RSP_GNT = gate_rsp;
  assign TX_UNREQ_GNT = gate_unreq;
  assign AVS_READDATA = s_reg.rdata;
  assign AVS_WAITREQUEST = s_reg.waitreq;
  assign IRQ = s_reg.irq;

  ////////////////////////////////////////////////////////////////////////////////
  // cycles since power up spent with any channel not yet reachable
  logic [CNT_W-1:0] t4_cnt;
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      t4_cnt <= '0;
    end else if (s_reg.pwr_s2 && (|(~ch_rdy))) begin
      t4_cnt <= t4_cnt + CNT_W'(1);
    end else begin
      t4_cnt <= '0;
    end
  end

  property p_t4_bound;
    @(posedge MCLK) disable iff (!RST_N)
      t4_cnt <= CNT_W'(T4_CYC);
  endproperty
  a_t4_bound: assert property (p_t4_bound) else $error("channel missed T4 after power up");

  property p_pkg_ready;
    @(posedge MCLK) disable iff (!RST_N)
      ($past(pkg_cmd) && RSP.valid) |-> ($past(s_reg.pst) == PK_READY);
  endproperty
  a_pkg_ready: assert property (p_pkg_ready) else $error("package answered while not ready");

  property p_sel_normal;
    @(posedge MCLK) disable iff (!RST_N)
      (pkg_cmd && pkg_sel_op && s_reg.pst == PK_READY && s_reg.pwr_s2 && (|ch_init))
      |=> (RSP.valid && RSP.ok && !RSP.fail_init);
  endproperty
  a_sel_normal: assert property (p_sel_normal) else $error("select not answered normally");

  property p_ch_accept;
    @(posedge MCLK) disable iff (!RST_N)
      (!pkg_cmd && (|(hit & ch_rdy)) && s_reg.pwr_s2) |=> RSP.valid;
  endproperty
  a_ch_accept: assert property (p_ch_accept) else $error("ready channel did not answer");

  property p_ch_refuse;
    @(posedge MCLK) disable iff (!RST_N)
      (CMD.valid && !pkg_cmd && (|hit) && !(|(hit & ch_rdy))) |=> !RSP.valid;
  endproperty
  a_ch_refuse: assert property (p_ch_refuse) else $error("not-ready channel answered");

  property p_init_fail;
    @(posedge MCLK) disable iff (!RST_N)
      (!pkg_cmd && fail_init_now && s_reg.pwr_s2) |=> (RSP.valid && RSP.fail_init && !RSP.ok);
  endproperty
  a_init_fail: assert property (p_init_fail) else $error("initial state command not failed");

  property p_power_down;
    @(posedge MCLK) disable iff (!RST_N)
      (!s_reg.pwr_s2 [*2]) |-> (!RSP.valid && !TX_DRV_EN && !s_reg.selected);
  endproperty
  a_power_down: assert property (p_power_down) else $error("activity while powered down");

endmodule : sb_pkg_ctrl
`default_nettype wire

// [bench/mgmt_model.sv]
// management controller model: issues commands and collects the response
`timescale 1ns/10ps
`default_nettype none
module mgmt_model
  import sb_state_pkg::*;
(
  input wire logic clk,
  input wire rsp_t rsp,
  output var cmd_t cmd
);
  rsp_t got;

  initial cmd = '0;

  // one-cycle command; released fields show their inverse, never a stale copy
  task automatic send(input logic [7:0] c, input logic [7:0] o, input logic oem,
      input logic arg);
    @(posedge clk);
    cmd <= '{valid: 1'b1, chid: c, op: o, oem: oem, arg: arg};
    @(posedge clk);
    cmd <= ~cmd;
    @(posedge clk);
    got = rsp;
  endtask : send
endmodule : mgmt_model
`default_nettype wire

// [bench/testbench.sv]
// self-checking bench: register bus, command port and transmit gating
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import sb_state_pkg::*;
  localparam int T4 = 400;
  logic mclk, rst_n, if_power, token, rsp_req, rd, wr, waitreq, drv, rgnt, irq;
  logic [1:0] unreq, ugnt;
  logic [4:0] addr;
  logic [31:0] wdata, rdata;
  cmd_t cmd;
  rsp_t rsp;
  int errors, checked;

  mgmt_model pm (.clk(mclk), .rsp(rsp), .cmd(cmd));

  sb_pkg_ctrl #(.NUM_CH(2), .T4_CYC(T4), .PKG_DLY(4), .CH_DLY(8)) DUT (
    .MCLK(mclk), .RST_N(rst_n), .IF_POWER(if_power), .ARB_TOKEN(token),
    .PKG_ID_STRAP(3'h5), .CMD(cmd), .RSP(rsp), .TX_RSP_REQ(rsp_req),
    .TX_UNREQ_REQ(unreq), .TX_DRV_EN(drv), .TX_RSP_GNT(rgnt), .TX_UNREQ_GNT(ugnt),
    .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
    .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .IRQ(irq));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  // holds the request until waitrequest is sampled low
  task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d,
      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    if (n >= 50) chk("waitrequest", 32'h0, 32'h1);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : av

  task automatic rreg(input logic [4:0] a, input logic [31:0] e, input string s);
    logic [31:0] q;
    av(1'b0, a, 32'h0, q);
    chk(s, e, q);
  endtask : rreg

  task automatic wreg(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    av(1'b1, a, d, q);
  endtask : wreg

  task automatic cmdc(input logic [7:0] c, input logic [7:0] o, input logic oem,
      input logic arg, input logic [2:0] e, input string s);
    pm.send(c, o, oem, arg);
    chk(s, {29'h0, e}, {29'h0, pm.got});
  endtask : cmdc

  // grants settle within a few cycles of any change, token sync included
  task automatic txchk(input logic [3:0] e, input string s);
    repeat (5) @(posedge mclk);
    chk(s, {28'h0, e}, {28'h0, drv, rgnt, ugnt});
  endtask : txchk

  task automatic results;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial begin
    #100000;
    errors++;
    $display("watchdog expired");
    results();
  end

  initial begin
    {rst_n, if_power, token, rsp_req, rd, wr} = '0;
    unreq = '0;
    addr = '0;
    wdata = '0;
    errors = 0;
    checked = 0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    rreg(REG_CTRL, 32'h2, "ctrl reset");
    rreg(REG_IRQ_MASK, 32'h0, "mask reset");
    wreg(5'h10, 32'hFFFFFFFF);
    rreg(5'h10, 32'h0, "unmapped");
    $display("test registers done");
    @(posedge mclk);
    if_power <= 1'b1;
    cmdc(8'hBF, OP_SELECT, 1'b0, 1'b1, 3'b000, "early select");
    cmdc(8'hA0, OP_CLEAR_INIT, 1'b0, 1'b0, 3'b000, "early channel");
    repeat (T4) @(posedge mclk);
    rreg(REG_STATUS, 32'h30B, "status after power up");
    $display("test power up done");
    rsp_req <= 1'b1;
    unreq <= 2'b11;
    txchk(4'h0, "deselected tx");
    cmdc(8'hBF, OP_SELECT, 1'b0, 1'b1, 3'b110, "select");
    txchk(4'b1100, "arbitration off tx");
    cmdc(8'hA0, OP_CH_ENABLE, 1'b0, 1'b0, 3'b101, "enable in initial");
    cmdc(8'hA0, 8'hFF, 1'b1, 1'b0, 3'b110, "vendor in initial");
    cmdc(8'hA0, OP_CLEAR_INIT, 1'b0, 1'b0, 3'b110, "clear initial");
    cmdc(8'hA0, OP_CH_ENABLE, 1'b0, 1'b0, 3'b110, "enable");
    cmdc(8'h40, OP_CH_ENABLE, 1'b0, 1'b0, 3'b000, "foreign id");
    cmdc(8'hA1, OP_CLEAR_INIT, 1'b0, 1'b0, 3'b110, "ch1 clear");
    cmdc(8'hA1, OP_CH_ENABLE, 1'b0, 1'b0, 3'b110, "ch1 enable");
    cmdc(8'hA1, OP_CH_DISABLE, 1'b0, 1'b0, 3'b110, "ch1 disable");
    cmdc(8'hA1, OP_CH_RESET, 1'b0, 1'b0, 3'b110, "ch1 reset");
    cmdc(8'hA1, OP_CH_DISABLE, 1'b0, 1'b0, 3'b101, "ch1 initial");
    rsp_req <= 1'b0;
    txchk(4'b1001, "unrequested grant");
    $display("test channels done");
    cmdc(8'hBF, OP_SELECT, 1'b0, 1'b0, 3'b110, "select arbitrated");
    txchk(4'h0, "no token");
    token <= 1'b1;
    txchk(4'b1001, "token held");
    $display("test arbitration done");
    wreg(REG_IRQ_MASK, 32'h8);
    @(posedge mclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    rreg(REG_IRQ_STAT, 32'h7, "irq status");
    wreg(REG_IRQ_MASK, 32'h1);
    wreg(REG_CTRL, 32'h3);
    repeat (5) @(posedge mclk);
    chk("grant after forced initial", 32'h0, {30'h0, ugnt});
    chk("irq raised", 32'h1, {31'h0, irq});
    rreg(REG_IRQ_STAT, 32'h1, "irq status forced");
    repeat (2) @(posedge mclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test interrupt done");
    cmdc(8'hBF, OP_DESELECT, 1'b0, 1'b0, 3'b110, "deselect");
    rsp_req <= 1'b1;
    txchk(4'h0, "deselect tx");
    cmdc(8'hBF, OP_SELECT, 1'b0, 1'b1, 3'b110, "reselect");
    if_power <= 1'b0;
    txchk(4'h0, "power down tx");
    cmdc(8'hBF, OP_SELECT, 1'b0, 1'b1, 3'b000, "power down select");
    rreg(REG_IRQ_STAT, 32'hA, "irq status power down");
    $display("test power down done");
    results();
  end
endmodule : testbench
`default_nettype wire
